// [rtl/dtip_core.sv]
// Interrupt prioritizer and vector supply for a CPU and a coprocessor
// Summary of operation
// R01 - Winning level becomes new current level
// R02 - Route bit set steers channel to coprocessor
// R03 - Coprocessor flags raise CPU vector base+2n
// R04 - Flag interrupts share one priority, highest wins
// R05 - Two decoders, coprocessor ignores thread level
// R06 - Coprocessor request carries priority MSB flag
// R07 - Vector chosen at the moment of request
// R08 - Nothing pending gives spurious vector base+0x10
// R09 - Sources hold requests until service starts
// R10 - Three fixed reset vectors in priority order
// R11 - Trap, software interrupt, system call next
// R12 - Access violations, then the non-maskable pin request
// R13 - Maskable channels ordered by level, spurious last
// R14 - Non-maskable always beats maskable
// R15 - 16-bit vectors, default base 0xff00
// R16 - Nesting up to seven levels via mask
// R17 - Wake only on qualified CPU-routed request
// R18 - Non-maskable pin wakes even when masked
// R19 - Coprocessor channels wake the coprocessor only
// R20 - Stacked level restored by CPU on return
// R21 - Level zero disables a channel
// R22 - Equal levels: higher vector wins
// R23 - Level must exceed current level
// R24 - Reset: enabled, CPU-routed, level one
// R25 - Decoders re-evaluate every clock
`include "dtip_params.svh"
`timescale 1ns/100ps
`default_nettype none
module dtip_core #(
    parameter int N = 128
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic [31:0]              wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic [N-1:0]        chan_req,
    input  wire logic                irq_pin_b,
    input  wire logic                nonmaskable_pin_request_b,
    input  wire logic                rst_pin_group_req,
    input  wire logic                rst_clock_monitor_req,
    input  wire logic                watchdog_reset_source,
    input  wire logic                trap_req,
    input  wire logic                swi_req,
    input  wire logic                sys_req,
    input  wire logic                coproc_access_viol,
    input  wire logic                cpu_access_viol,
    input  wire logic                mask_i_bit,
    input  wire logic                mask_x_bit,
    input  wire dtip_pkg::dtip_level_t current_interrupt_level,
    input  wire logic                cpu_vec_req,
    output logic                     cpu_vec_ack,
    output dtip_pkg::dtip_vec_t      cpu_vec_addr,
    output dtip_pkg::dtip_level_t    cpu_new_level,
    input  wire logic [N-1:0]        coproc_chan_flags,
    input  wire logic                coproc_global_irq_enable,
    output logic                     coproc_req_valid,
    output dtip_pkg::dtip_chan_t     coproc_req_chan,
    output logic                     coproc_req_hiprio,
    input  wire logic                cpu_low_power,
    output logic                     cpu_wake,
    output logic                     cpu_wake_no_isr,
    output logic                     coproc_wake
);
    import dtip_pkg::*;

    logic [2:0]     prio_mem [N];
    logic           route_mem [N];
    logic [7:0]     vec_base;
    dtip_chan_t     cfg_sel;
    dtip_level_t    cop_prio;
    logic [1:0]     irq_sync;
    logic [1:0]     nonmaskable_pin_request_sync;
    logic           irq_act;
    logic           nonmaskable_pin_request_act;
    logic [N-1:0]   cpu_req;
    logic [N-1:0]   cop_req;
    logic [3*N-1:0] cpu_prio;
    logic [3*N-1:0] cop_prio_vec;
    logic           cpu_found;
    dtip_chan_t     cpu_idx;
    dtip_level_t    cpu_lvl;
    logic           cop_found;
    dtip_chan_t     cop_idx;
    dtip_level_t    cop_lvl;
    logic           mask_ok;
    dtip_vec_t      next_vec;
    dtip_level_t    next_level;
    logic           bus_req;
    logic           wr_en;
    logic           sel_valid;
    logic [7:0]     cfg_rd;
    logic           irq_from_pin;

    // Pin requests are asynchronous, two flops before use
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_sync  <= 2'b11;
            nonmaskable_pin_request_sync <= 2'b11;
        end else begin
            irq_sync  <= {irq_sync[0], irq_pin_b};
            nonmaskable_pin_request_sync <= {nonmaskable_pin_request_sync[0], nonmaskable_pin_request_b};
        end
    end
    assign irq_act  = !irq_sync[1];
    assign nonmaskable_pin_request_act = !nonmaskable_pin_request_sync[1];

    // Request qualification per channel
    always_comb begin
        for (int i = 0; i < N; i++) begin
            irq_from_pin = (7'(i) == `DTIP_CH_IRQ) && irq_act;
            // R02 route select
            cop_req[i] = route_mem[i] && chan_req[i];
            cop_prio_vec[3*i +: 3] = prio_mem[i];
            // R03 flag raised CPU requests
            if (route_mem[i]) begin
                cpu_req[i] = coproc_chan_flags[i] && coproc_global_irq_enable;
                // R04 shared priority
                cpu_prio[3*i +: 3] = cop_prio;
            end else begin
                cpu_req[i] = chan_req[i] || irq_from_pin;
                // R21 level zero never exceeds threshold
                cpu_prio[3*i +: 3] = prio_mem[i];
            end
        end
    end

    // R05 CPU decoder, threshold is current level
    // R23 strictly greater than current level
    // R22 ties to the higher vector
    // R25 combinational, fresh each cycle
    dtip_prio_decoder #(.N(N), .W(7)) u_cpu_dec (
        .req       (cpu_req),
        .prio      (cpu_prio),
        .threshold (current_interrupt_level),
        .found     (cpu_found),
        .idx       (cpu_idx),
        .level     (cpu_lvl)
    );

    // R05 coprocessor decoder ignores thread level
    dtip_prio_decoder #(.N(N), .W(7)) u_cop_dec (
        .req       (cop_req),
        .prio      (cop_prio_vec),
        .threshold (3'h0),
        .found     (cop_found),
        .idx       (cop_idx),
        .level     (cop_lvl)
    );

    // R16 mask bit gates nesting of maskable requests
    assign mask_ok = cpu_found && !mask_i_bit;

    // Exception priority chain for the vector
    always_comb begin
        next_level = current_interrupt_level;
        // R10 fixed reset vectors
        if (rst_pin_group_req)
            next_vec = `DTIP_VEC_RST_PIN;
        else if (rst_clock_monitor_req)
            next_vec = `DTIP_VEC_RST_CM;
        else if (watchdog_reset_source)
            next_vec = `DTIP_VEC_RST_WD;
        // R11 software exceptions
        else if (trap_req)
            next_vec = {vec_base, `DTIP_OFS_TRAP};
        else if (swi_req)
            next_vec = {vec_base, `DTIP_OFS_SWI};
        else if (sys_req)
            next_vec = {vec_base, `DTIP_OFS_SYS};
        // R12 violations and non-maskable pin request
        else if (coproc_access_viol)
            next_vec = {vec_base, `DTIP_OFS_CAV};
        else if (cpu_access_viol)
            next_vec = {vec_base, `DTIP_OFS_AV};
        else if (nonmaskable_pin_request_act && !mask_x_bit)
            next_vec = {vec_base, `DTIP_OFS_NONMASKABLE_PIN_REQUEST};
        // R13 R14 maskable only after all of the above
        else if (mask_ok) begin
            next_vec   = {vec_base, cpu_idx, 1'b0};
            next_level = cpu_lvl;
        end
        // R08 spurious fallback
        else
            next_vec = {vec_base, `DTIP_OFS_SPUR};
    end

    // R07 vector latched at the request cycle
    // R01 new current level delivered with vector
    // R20 restore on return handled by the CPU stack
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_vec_ack   <= 1'b0;
            cpu_vec_addr  <= '0;
            cpu_new_level <= '0;
        end else begin
            cpu_vec_ack <= cpu_vec_req;
            if (cpu_vec_req) begin
                cpu_vec_addr  <= next_vec;
                cpu_new_level <= next_level;
            end
        end
    end

    // R06 coprocessor request with priority MSB
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            coproc_req_valid  <= 1'b0;
            coproc_req_chan   <= '0;
            coproc_req_hiprio <= 1'b0;
        end else begin
            coproc_req_valid  <= cop_found;
            coproc_req_chan   <= cop_idx;
            coproc_req_hiprio <= cop_found && cop_lvl[`DTIP_PRIO_MSB];
        end
    end

    // R17 wake on qualified CPU request
    // R18 non-maskable pin wakes regardless of mask
    // R19 coprocessor channels wake coprocessor only
    assign cpu_wake = cpu_low_power && (mask_ok || nonmaskable_pin_request_act);
    assign cpu_wake_no_isr = cpu_low_power && nonmaskable_pin_request_act && mask_x_bit;
    assign coproc_wake = cop_found;

    // Wishbone decode, one wait state, unmapped reads zero
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en   = bus_req && wb_we_i && wb_sel_i[0];
    assign sel_valid = cfg_sel >= `DTIP_CH_FIRST && cfg_sel <= `DTIP_CH_IRQ;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= bus_req;
    end

    // Plain control registers
    // R15 default base gives table at top of memory
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vec_base <= `DTIP_VBASE_RST;
            cfg_sel  <= `DTIP_SEL_RST;
            cop_prio <= `DTIP_COP_PRIO_RST;
        end else if (wr_en) begin
            unique case ({wb_adr_i[7:2], 2'b00})
                `DTIP_REG_VBASE:    vec_base <= wb_dat_i[7:0];
                `DTIP_REG_CFG_SEL:  cfg_sel  <= wb_dat_i[7:1];
                `DTIP_REG_COP_PRIO: cop_prio <= wb_dat_i[2:0];
                default: ;
            endcase
        end
    end

    // R24 channel configuration, CPU-routed level one at reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < N; i++) begin
                prio_mem[i]  <= `DTIP_PRIO_RST;
                route_mem[i] <= 1'b0;
            end
        end else if (wr_en && sel_valid &&
                     {wb_adr_i[7:2], 2'b00} == `DTIP_REG_CFG_DATA) begin
            prio_mem[cfg_sel]  <= wb_dat_i[2:0];
            route_mem[cfg_sel] <= (cfg_sel != `DTIP_CH_IRQ) &&
                                  wb_dat_i[`DTIP_ROUTE_BIT];
        end
    end

    // Configuration readback for the selected channel
    always_comb begin
        cfg_rd = 8'h00;
        if (cfg_sel == `DTIP_CH_SPUR)
            cfg_rd = `DTIP_SPUR_CFG;
        else if (sel_valid)
            cfg_rd = {route_mem[cfg_sel], 4'h0, prio_mem[cfg_sel]};
    end

    // Read data registered with the acknowledge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            wb_dat_o <= '0;
        else if (bus_req) begin
            unique case ({wb_adr_i[7:2], 2'b00})
                `DTIP_REG_VBASE:    wb_dat_o <= {24'h0, vec_base};
                `DTIP_REG_CFG_SEL:  wb_dat_o <= {24'h0, cfg_sel, 1'b0};
                `DTIP_REG_CFG_DATA: wb_dat_o <= {24'h0, cfg_rd};
                `DTIP_REG_COP_PRIO: wb_dat_o <= {29'h0, cop_prio};
                `DTIP_REG_STATUS:   wb_dat_o <= {2'h0, nonmaskable_pin_request_act, irq_act,
                                                 cop_found, cpu_found,
                                                 cpu_lvl, cpu_idx,
                                                 cpu_vec_addr};
                default:            wb_dat_o <= '0;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    vec_ack_a: assert property (cpu_vec_req |=> cpu_vec_ack) // R07
        else $error("vector ack missing");
    reset_vec_a: assert property (cpu_vec_req && rst_pin_group_req // R10
        |=> cpu_vec_addr == `DTIP_VEC_RST_PIN)
        else $error("pin reset vector wrong");
    spurious_vec_a: assert property (cpu_vec_req && !mask_ok // R08
        && !(nonmaskable_pin_request_act && !mask_x_bit) && !rst_pin_group_req && !rst_clock_monitor_req
        && !watchdog_reset_source && !trap_req && !swi_req && !sys_req
        && !coproc_access_viol && !cpu_access_viol
        |=> cpu_vec_addr == {vec_base, `DTIP_OFS_SPUR})
        else $error("spurious vector wrong");
    level_load_a: assert property (cpu_vec_req && mask_ok && !swi_req // R01
        && !trap_req && !sys_req && !rst_pin_group_req && !rst_clock_monitor_req
        && !watchdog_reset_source && !coproc_access_viol && !cpu_access_viol
        && !(nonmaskable_pin_request_act && !mask_x_bit) |=> cpu_new_level == $past(cpu_lvl))
        else $error("new level not from winner");
    swi_over_mask_a: assert property (cpu_vec_req && swi_req && !trap_req // R14
        && !rst_pin_group_req && !rst_clock_monitor_req && !watchdog_reset_source
        |=> cpu_vec_addr == {vec_base, `DTIP_OFS_SWI})
        else $error("software interrupt lost to lower source");
    hiprio_flag_a: assert property (cop_found |=> coproc_req_valid // R06
        && coproc_req_hiprio == $past(cop_lvl[`DTIP_PRIO_MSB]))
        else $error("coprocessor priority flag wrong");
    level_thresh_a: assert property (cpu_found // R23
        |-> cpu_lvl > current_interrupt_level)
        else $error("winner level not above current level");
    wake_qual_a: assert property (cpu_wake && !nonmaskable_pin_request_act // R17
        |-> !mask_i_bit && cpu_found && cpu_low_power)
        else $error("unqualified wake");

    vec_maskable_c: cover property (cpu_vec_req && mask_ok ##1 cpu_vec_ack);
    vec_spurious_c: cover property (cpu_vec_req && !mask_ok && !nonmaskable_pin_request_act);
    cop_hiprio_c: cover property (coproc_req_valid && coproc_req_hiprio);
    wake_no_isr_c: cover property (cpu_wake_no_isr);
endmodule
`default_nettype wire

// [rtl/dtip_params.svh]
// Constants for the dual target interrupt prioritizer
`ifndef DTIP_PARAMS_SVH
`define DTIP_PARAMS_SVH
// Register byte addresses
`define DTIP_REG_VBASE    8'h00
`define DTIP_REG_CFG_SEL  8'h04
`define DTIP_REG_CFG_DATA 8'h08
`define DTIP_REG_COP_PRIO 8'h0c
`define DTIP_REG_STATUS   8'h10
// Reset values
`define DTIP_VBASE_RST    8'hff
`define DTIP_PRIO_RST     3'h1
`define DTIP_COP_PRIO_RST 3'h1
`define DTIP_SEL_RST      7'h00
// Configuration data fields
`define DTIP_ROUTE_BIT    7
`define DTIP_PRIO_MSB     2
`define DTIP_SPUR_CFG     8'h07
// Channel numbers (vector offset divided by two)
`define DTIP_CH_FIRST     7'h0d
`define DTIP_CH_IRQ       7'h79
`define DTIP_CH_SPUR      7'h08
// Fixed reset vectors
`define DTIP_VEC_RST_PIN  16'hfffe
`define DTIP_VEC_RST_CM   16'hfffc
`define DTIP_VEC_RST_WD   16'hfffa
// Vector offsets from the base
`define DTIP_OFS_TRAP     8'hf8
`define DTIP_OFS_SWI      8'hf6
`define DTIP_OFS_SYS      8'h12
`define DTIP_OFS_CAV      8'h16
`define DTIP_OFS_AV       8'h14
`define DTIP_OFS_NONMASKABLE_PIN_REQUEST     8'hf4
`define DTIP_OFS_SPUR     8'h10
`endif

// [rtl/dtip_pkg.sv]
// Types for the dual target interrupt prioritizer
package dtip_pkg;
    typedef logic [2:0]  dtip_level_t;
    typedef logic [15:0] dtip_vec_t;
    typedef logic [6:0]  dtip_chan_t;
endpackage

// [rtl/dtip_prio_decoder.sv]
// Priority decoder: highest level wins, ties go to the higher channel
`timescale 1ns/100ps
`default_nettype none
module dtip_prio_decoder #(
    parameter int N = 128,
    parameter int W = 7
) (
    input  wire logic [N-1:0]   req,
    input  wire logic [3*N-1:0] prio,
    input  wire logic [2:0]     threshold,
    output logic                found,
    output logic [W-1:0]        idx,
    output logic [2:0]          level
);
    // Ascending scan with >= lets the higher channel win ties
    always_comb begin
        found = 1'b0;
        idx   = '0;
        level = '0;
        for (int i = 0; i < N; i++) begin
            if (req[i] && prio[3*i +: 3] > threshold &&
                (!found || prio[3*i +: 3] >= level)) begin
                found = 1'b1;
                idx   = W'(i);
                level = prio[3*i +: 3];
            end
        end
    end
endmodule
`default_nettype wire

// [verif/dtip_cpu_model.sv]
// Behavioural CPU model: fetches vectors and tracks its current level
`timescale 1ns/100ps
`default_nettype none
module dtip_cpu_model (
    input  wire logic                  clk,
    output var logic                   cpu_vec_req,
    input  wire logic                  cpu_vec_ack,
    input  wire dtip_pkg::dtip_vec_t   cpu_vec_addr,
    input  wire dtip_pkg::dtip_level_t cpu_new_level,
    output var dtip_pkg::dtip_level_t  current_interrupt_level
);
    import dtip_pkg::*;
    dtip_level_t stk[$];
    dtip_vec_t   vec;

    // Idle request, level zero
    initial begin
        cpu_vec_req = 1'b0;
        current_interrupt_level = 3'h0;
        vec = 16'h0000;
    end

    // One-cycle request, answer taken at the ack edge
    task automatic fetch();
        @(posedge clk);
        cpu_vec_req <= 1'b1;
        @(posedge clk);
        cpu_vec_req <= 1'b0;
        // Wait for the answer, the bench timeout ends a hang
        while (cpu_vec_ack !== 1'b1) begin
            @(posedge clk);
        end
        vec = cpu_vec_addr;
        stk.push_back(current_interrupt_level);
        current_interrupt_level <= cpu_new_level;
    endtask

    task automatic return_from_interrupt_instr();
        @(posedge clk);
        current_interrupt_level <= stk.pop_back();
    endtask

    // Direct level load by software
    task automatic set_level(input dtip_level_t l);
        @(posedge clk);
        current_interrupt_level <= l;
    endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the dual target interrupt prioritizer
`timescale 1ns/100ps
`default_nettype none
module tb;
    import dtip_pkg::*;
    logic         clk = 1'b0;
    logic         rst_b = 1'b0;
    logic         wb_cyc_i = 1'b0;
    logic         wb_stb_i = 1'b0;
    logic         wb_we_i = 1'b0;
    logic [7:0]   wb_adr_i = 8'h00;
    logic [3:0]   wb_sel_i = 4'h0;
    logic [31:0]  wb_dat_i = 32'h0;
    logic [31:0]  wb_dat_o;
    logic         wb_ack_o;
    logic [127:0] chan_req = '0;
    logic [127:0] flags = '0;
    logic [8:0]   fx = 9'h000;
    logic         mask_i = 1'b0;
    logic         mask_x = 1'b0;
    logic         gie = 1'b0;
    logic         low_pwr = 1'b0;
    logic         irq_b = 1'b1;
    logic [3:0]   sel = 4'hf;
    logic         vreq, vack, cvalid, chi, cwake, cwake_ni, xwake;
    dtip_vec_t    vaddr;
    dtip_level_t  nlvl, cur_lvl;
    dtip_chan_t   cchan;
    logic [31:0]  q;
    int           n_errors = 0;
    int           samples_checked = 0;
    int           cycles = 0;
    // Fixed source vectors, index 0 is the X pin
    localparam logic [15:0] FXV [9] = '{16'hfff4, 16'hff14, 16'hff16, 16'hff12,
        16'hfff6, 16'hfff8, 16'hfffa, 16'hfffc, 16'hfffe};

    // Clock
    always #4 clk = ~clk;

    dtip_core i_dtip_core (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .chan_req(chan_req), .irq_pin_b(irq_b),
        .nonmaskable_pin_request_b(~fx[0]), .rst_pin_group_req(fx[8]),
        .rst_clock_monitor_req(fx[7]), .watchdog_reset_source(fx[6]),
        .trap_req(fx[5]), .swi_req(fx[4]), .sys_req(fx[3]),
        .coproc_access_viol(fx[2]), .cpu_access_viol(fx[1]),
        .mask_i_bit(mask_i), .mask_x_bit(mask_x), .current_interrupt_level(cur_lvl),
        .cpu_vec_req(vreq), .cpu_vec_ack(vack), .cpu_vec_addr(vaddr),
        .cpu_new_level(nlvl), .coproc_chan_flags(flags),
        .coproc_global_irq_enable(gie), .coproc_req_valid(cvalid),
        .coproc_req_chan(cchan), .coproc_req_hiprio(chi), .cpu_low_power(low_pwr),
        .cpu_wake(cwake), .cpu_wake_no_isr(cwake_ni), .coproc_wake(xwake));

    dtip_cpu_model i_dtip_cpu_model (.clk(clk), .cpu_vec_req(vreq),
        .cpu_vec_ack(vack), .cpu_vec_addr(vaddr), .cpu_new_level(nlvl),
        .current_interrupt_level(cur_lvl));

    // Verdict and end of run
    task automatic final_report();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Compare seen against expected
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // Classic single Wishbone cycle
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= sel;
        // Wait for ack, the bench timeout ends a hang
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    // Select a channel by vector offset and write its config
    task automatic cfg(input logic [7:0] o, input logic [7:0] d);
        wb(1'b1, 8'h04, {24'h0, o}, q);
        wb(1'b1, 8'h08, {24'h0, d}, q);
    endtask

    // Fetch a vector and compare it
    task automatic fv(input logic [15:0] e);
        i_dtip_cpu_model.fetch();
        chk(i_dtip_cpu_model.vec, e);
    endtask

    task automatic t_regs();
        wb(1'b0, 8'h00, 32'h0, q);
        chk(q, 32'hff);
        wb(1'b0, 8'h0c, 32'h0, q);
        chk(q, 32'h1);
        wb(1'b1, 8'h04, 32'hf0, q);
        wb(1'b0, 8'h08, 32'h0, q);
        chk(q, 32'h1);
        cfg(8'hf2, 8'h81);
        wb(1'b0, 8'h08, 32'h0, q);
        chk(q, 32'h1);
        wb(1'b1, 8'h14, 32'h55, q);
        wb(1'b0, 8'h14, 32'h0, q);
        chk(q, 32'h0);
        wb(1'b1, 8'h00, 32'h80, q);
        fv(16'h8010);
        wb(1'b1, 8'h00, 32'hff, q);
        // Write without the low byte enable is ignored
        sel = 4'he;
        wb(1'b1, 8'h00, 32'h80, q);
        sel = 4'hf;
        wb(1'b0, 8'h00, 32'h0, q);
        chk(q, 32'hff);
    endtask

    task automatic t_fixed();
        @(posedge clk);
        fx <= 9'h1ff;
        chan_req <= 128'h1 << 120;
        for (int i = 8; i >= 0; i--) begin
            repeat (3) @(posedge clk);
            fv(FXV[i]);
            fx[i] <= 1'b0;
        end
        repeat (3) @(posedge clk);
        fv(16'hfff0);
        chk(nlvl, 32'h1);
    endtask

    task automatic t_mask();
        i_dtip_cpu_model.set_level(3'h0);
        // Requests held until serviced
        chan_req <= (128'h1 << 120) | (128'h1 << 13);
        fv(16'hfff0);
        cfg(8'h1a, 8'h05);
        fv(16'hff1a);
        chk(nlvl, 32'h5);
        fv(16'hff10);
        i_dtip_cpu_model.return_from_interrupt_instr();
        i_dtip_cpu_model.return_from_interrupt_instr();
        @(posedge clk);
        chk(cur_lvl, 32'h1);
        i_dtip_cpu_model.set_level(3'h0);
        cfg(8'h1a, 8'h00);
        fv(16'hfff0);
        i_dtip_cpu_model.set_level(3'h0);
        mask_i <= 1'b1;
        fv(16'hff10);
        mask_i <= 1'b0;
        chan_req <= '0;
        fv(16'hff10);
    endtask

    task automatic t_coproc();
        cfg(8'h40, 8'h85);
        chan_req <= 128'h1 << 32;
        low_pwr <= 1'b1;
        repeat (2) @(posedge clk);
        chk(cvalid, 32'h1);
        chk(cchan, 32'h20);
        chk(chi, 32'h1);
        chk(cwake, 32'h0);
        chk(xwake, 32'h1);
        i_dtip_cpu_model.set_level(3'h7);
        repeat (2) @(posedge clk);
        chk(cvalid, 32'h1);
        i_dtip_cpu_model.set_level(3'h0);
        low_pwr <= 1'b0;
        cfg(8'h40, 8'h83);
        repeat (2) @(posedge clk);
        chk(chi, 32'h0);
        fv(16'hff10);
        cfg(8'h44, 8'h82);
        wb(1'b1, 8'h0c, 32'h4, q);
        flags <= (128'h1 << 32) | (128'h1 << 34);
        gie <= 1'b1;
        fv(16'hff44);
        chk(nlvl, 32'h4);
        i_dtip_cpu_model.set_level(3'h0);
        gie <= 1'b0;
        fv(16'hff10);
    endtask

    task automatic t_wake();
        @(posedge clk);
        chan_req <= 128'h1 << 120;
        flags <= '0;
        low_pwr <= 1'b1;
        @(posedge clk);
        chk(cwake, 32'h1);
        mask_i <= 1'b1;
        @(posedge clk);
        chk(cwake, 32'h0);
        fx <= 9'h001;
        mask_x <= 1'b1;
        repeat (3) @(posedge clk);
        chk(cwake, 32'h1);
        chk(cwake_ni, 32'h1);
        fv(16'hff10);
        // Maskable pin request lands on its own channel
        mask_i <= 1'b0;
        mask_x <= 1'b0;
        fx <= 9'h000;
        chan_req <= '0;
        low_pwr <= 1'b0;
        irq_b <= 1'b0;
        repeat (3) @(posedge clk);
        wb(1'b0, 8'h10, 32'h0, q);
        chk(q, 32'h14f9ff10);
        fv(16'hfff2);
        chk(nlvl, 32'h1);
        irq_b <= 1'b1;
    endtask

    // Timeout on a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            final_report();
        end
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_fixed();
        t_mask();
        t_coproc();
        t_wake();
        final_report();
    end
endmodule
`default_nettype wire
